//--- asbm_consts.svh
// Purpose: named constants for the accumulator, string and block-copy execution unit
// Assumes: 16-bit data words, 24-bit byte addresses (8-bit bank plus 16-bit offset)
// Notes:   cycle figures are instruction totals or base and per-element parts, counted on sys_clk
`ifndef ASBM_CONSTS_SVH
`define ASBM_CONSTS_SVH
`define ASBM_SWAP_CYC      4'h3
`define ASBM_ACC_WORD_EXCHANGE_ALIAS_CYC      4'h2
`define ASBM_EXTB_CYC      4'h1
`define ASBM_WORD_SIGN_WIDEN_CYC      4'h2
`define ASBM_BYTE_ZERO_WIDEN_CYC      4'h1
`define ASBM_STR_BASE      4'h2
`define ASBM_STR_PER       4'h6
`define ASBM_COPY_ZERO_CYC 4'h4
`define ASBM_SCAN_ZERO_CYC 4'h3
`define ASBM_FILL_BASE     4'h6
`define ASBM_FILL_PER      4'h5
`define ASBM_BLK_BASE      4'h5
`define ASBM_BLK_PER       4'h5
`define ASBM_BLK_ZERO_CNT  9'h100
`define ASBM_BYTE_SIGN     7
`define ASBM_WORD_SIGN     15
`endif

//--- asbm_pkg.sv
// Purpose: types shared by the execution unit
// Assumes: nothing beyond the constants header
// Notes:   the operation code is a plain enum, its encoding is internal
package asbm_pkg;
  typedef enum logic [4:0] {
    ACC_BYTE_EXCHANGE, ACC_WORD_EXCHANGE, BYTE_SIGN_WIDEN, WORD_SIGN_WIDEN,
    BYTE_ZERO_WIDEN, WORD_ZERO_WIDEN, STRING_COPY, STRING_SCAN, STRING_FILL,
    BLOCK_COPY
  } asbm_op_type;

  typedef struct packed {
    asbm_op_type op;
    logic        wordSize;   // 1: 16-bit elements
    logic        down;       // 1: string copy and scan pointers decrement
    logic [7:0]  srcBank;
    logic [7:0]  dstBank;
    logic [23:0] blkSrc;     // block copy source address, already resolved
    logic [23:0] blkDst;     // block copy destination address, already resolved
    logic [7:0]  immCount;   // immediate_count
  } asbm_cmd_type;

  typedef struct packed {
    logic negative;
    logic zero;
    logic overflow;
    logic carry;
  } asbm_flags_type;

  typedef struct packed {
    logic        req;
    logic        write;
    logic        wordSize;
    logic [23:0] addr;
    logic [15:0] wdata;
  } asbm_mem_type;
endpackage : asbm_pkg

//--- asbm_element_step.sv
// Purpose: per-element pointer step and scan comparison
// Assumes: combinational, used by the sequencer each element
// Notes:   flags of the scan follow a subtract of acc low word from element
`timescale 1ns/1ps
`default_nettype none
`include "asbm_consts.svh"
module asbm_element_step (
  input  wire logic                  wordSize,
  input  wire logic                  down,
  input  wire logic [15:0]           ptrIn,
  input  wire logic [15:0]           element,
  input  wire logic [15:0]           accLow,
  output logic [15:0]                ptrOut,
  output logic                       match,
  output asbm_pkg::asbm_flags_type   scanFlags
);
  logic [16:0] diff;
  logic [15:0] stepSize;
  logic [15:0] opA;
  logic [15:0] opB;
  always_comb begin
    stepSize = wordSize ? 16'h0002 : 16'h0001;
    ptrOut   = down ? ptrIn - stepSize : ptrIn + stepSize;
    opA      = wordSize ? element : {8'h00, element[7:0]};
    opB      = wordSize ? accLow : {8'h00, accLow[7:0]};
    diff     = {1'b0, opA} - {1'b0, opB};
    match    = (opA == opB);
    if (wordSize) begin
      scanFlags.negative = diff[`ASBM_WORD_SIGN];
      scanFlags.zero     = (diff[15:0] == 16'h0000);
      scanFlags.overflow = (opA[15] != opB[15]) && (diff[15] != opA[15]);
      scanFlags.carry    = diff[16];
    end else begin
      scanFlags.negative = diff[`ASBM_BYTE_SIGN];
      scanFlags.zero     = (diff[7:0] == 8'h00);
      scanFlags.overflow = (opA[7] != opB[7]) && (diff[7] != opA[7]);
      scanFlags.carry    = diff[8];
    end
  end
endmodule : asbm_element_step
`default_nettype wire

//--- asbm_exec.sv
// Purpose: execution of accumulator, string and block-copy instructions
// Assumes: memory answers a request with rdValid one or more cycles later
// Notes:   cycle timing is padded to the documented totals by a wait counter
//
// What this block does
// - byte exchange swaps accumulator bytes, flags unchanged
// - word exchange swaps acc halves, two cycles
// - byte sign widen, sets N Z, one cycle
// - word sign widen fills high word, two cycles
// - zero widen clears upper bits, N cleared
// - upward byte copy, pointers increment, flags kept
// - downward copy decrements both pointers per element
// - word copies use same pointers and counter
// - scan compares, stops on match, sets NZVC
// - fill stores acc low, 5m+6 cycles
// - scan 3 if zero, 2+6m, 6n+4 matched
// - block copy immediate_count elements, zero means 256
// - block copy uses resolved 24-bit addresses, not the string banks
// - byte block copy, any address pair, flags kept
// - word block copy, same modes, 16-bit elements
`timescale 1ns/1ps
`default_nettype none
`include "asbm_consts.svh"
module asbm_exec #(
  parameter int CYC_W = 20
) (
  input  wire logic                    sys_clk,
  input  wire logic                    reset,
  input  wire logic                    start,
  input  wire asbm_pkg::asbm_cmd_type  cmd,
  input  wire logic [31:0]             accIn,
  input  wire logic [15:0]             counterIn,
  input  wire asbm_pkg::asbm_flags_type flagsIn,
  input  wire logic                    rdValid,
  input  wire logic [15:0]             rdData,
  output logic                         busy,
  output logic                         done,
  output logic [31:0]                  accOut,
  output logic [15:0]                  counterOut,
  output asbm_pkg::asbm_flags_type     flagsOut,
  output asbm_pkg::asbm_mem_type       mem
);
  typedef enum logic [2:0] {IDLE, READ, WAITRD, WRITE, PAD, FINISH} asbm_state_type;

  asbm_state_type           state_reg, state_next;
  asbm_pkg::asbm_cmd_type   cmd_reg, cmd_next;
  logic [31:0]              acc_reg, acc_next;
  logic [15:0]              cnt_reg, cnt_next;
  logic [8:0]               blk_reg, blk_next;
  logic [23:0]              bsrc_reg, bsrc_next;
  logic [23:0]              bdst_reg, bdst_next;
  logic [15:0]              data_reg, data_next;
  asbm_pkg::asbm_flags_type flags_reg, flags_next;
  logic [CYC_W-1:0]         wait_reg, wait_next;
  logic                     busy_reg, busy_next;
  logic                     done_reg, done_next;
  asbm_pkg::asbm_mem_type   mem_reg, mem_next;

  logic [15:0]              stepIn, stepOut;
  logic                     match;
  asbm_pkg::asbm_flags_type scanFlags;

  // ****************************************************************
  // element step
  // ****************************************************************
  asbm_element_step u_step (
    .wordSize  (cmd_reg.wordSize),
    .down      (cmd_reg.down),
    .ptrIn     (stepIn),
    .element   (data_reg),
    .accLow    (acc_reg[15:0]),
    .ptrOut    (stepOut),
    .match     (match),
    .scanFlags (scanFlags)
  );

  function automatic logic [CYC_W-1:0] cyc(input logic [3:0] c);
    cyc = CYC_W'(c);
  endfunction : cyc

  function automatic logic [23:0] step24(input logic [23:0] a, input logic w);
    step24 = a + (w ? 24'h000002 : 24'h000001);
  endfunction : step24

  function automatic logic [15:0] mask(input logic [15:0] d, input logic w);
    mask = w ? d : {8'h00, d[7:0]};
  endfunction : mask

  function automatic logic [15:0] step16(input logic [15:0] a, input logic w, input logic dn);
    step16 = dn ? a - (w ? 16'h0002 : 16'h0001) : a + (w ? 16'h0002 : 16'h0001);
  endfunction : step16

  // the shared step unit only ever walks the destination pointer, so no comb loop
  assign stepIn = acc_reg[31:16];

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    state_next   = state_reg;
    cmd_next     = cmd_reg;
    acc_next     = acc_reg;
    cnt_next     = cnt_reg;
    blk_next     = blk_reg;
    bsrc_next    = bsrc_reg;
    bdst_next    = bdst_reg;
    data_next    = data_reg;
    flags_next   = flags_reg;
    wait_next    = (wait_reg != '0) ? wait_reg - cyc(4'h1) : wait_reg;
    done_next    = 1'b0;
    mem_next     = '0;
    unique case (state_reg)
      IDLE: begin
        if (start) begin
          cmd_next   = cmd;
          acc_next   = accIn;
          cnt_next   = counterIn;
          flags_next = flagsIn;
          bsrc_next  = cmd.blkSrc;
          bdst_next  = cmd.blkDst;
          blk_next   = (cmd.immCount == 8'h00) ? `ASBM_BLK_ZERO_CNT
                                               : {1'b0, cmd.immCount};
          state_next = PAD;
          unique case (cmd.op)
            asbm_pkg::ACC_BYTE_EXCHANGE: begin
              acc_next[15:0] = {accIn[7:0], accIn[15:8]};
              wait_next      = cyc(`ASBM_SWAP_CYC);
            end
            asbm_pkg::ACC_WORD_EXCHANGE: begin
              acc_next  = {accIn[15:0], accIn[31:16]};
              wait_next = cyc(`ASBM_ACC_WORD_EXCHANGE_ALIAS_CYC);
            end
            asbm_pkg::BYTE_SIGN_WIDEN: begin
              acc_next[15:8]      = {8{accIn[`ASBM_BYTE_SIGN]}};
              flags_next.negative = accIn[`ASBM_BYTE_SIGN];
              flags_next.zero     = (accIn[7:0] == 8'h00);
              wait_next           = cyc(`ASBM_EXTB_CYC);
            end
            asbm_pkg::WORD_SIGN_WIDEN: begin
              acc_next[31:16]     = {16{accIn[`ASBM_WORD_SIGN]}};
              flags_next.negative = accIn[`ASBM_WORD_SIGN];
              flags_next.zero     = (accIn[15:0] == 16'h0000);
              wait_next           = cyc(`ASBM_WORD_SIGN_WIDEN_CYC);
            end
            asbm_pkg::BYTE_ZERO_WIDEN: begin
              acc_next[15:8]      = 8'h00;
              flags_next.negative = 1'b0;
              flags_next.zero     = (accIn[7:0] == 8'h00);
              wait_next           = cyc(`ASBM_BYTE_ZERO_WIDEN_CYC);
            end
            asbm_pkg::WORD_ZERO_WIDEN: begin
              acc_next[31:16]     = 16'h0000;
              flags_next.negative = 1'b0;
              flags_next.zero     = (accIn[15:0] == 16'h0000);
              wait_next           = cyc(`ASBM_BYTE_ZERO_WIDEN_CYC);
            end
            asbm_pkg::STRING_FILL: begin
              flags_next.negative = cmd.wordSize ? accIn[`ASBM_WORD_SIGN]
                                                 : accIn[`ASBM_BYTE_SIGN];
              flags_next.zero     = (mask(accIn[15:0], cmd.wordSize) == 16'h0000);
              wait_next           = cyc(`ASBM_FILL_BASE);
              state_next          = (counterIn == 16'h0000) ? PAD : WRITE;
            end
            asbm_pkg::BLOCK_COPY: begin
              wait_next  = cyc(`ASBM_BLK_BASE);
              state_next = READ;
            end
            default: begin
              wait_next  = (counterIn == 16'h0000) ?
                           cyc((cmd.op == asbm_pkg::STRING_SCAN) ? `ASBM_SCAN_ZERO_CYC
                                                               : `ASBM_COPY_ZERO_CYC)
                           : cyc(`ASBM_STR_BASE);
              state_next = (counterIn == 16'h0000) ? PAD : READ;
            end
          endcase
        end
      end
      READ: begin
        mem_next.req      = 1'b1;
        mem_next.wordSize = cmd_reg.wordSize;
        if (cmd_reg.op == asbm_pkg::BLOCK_COPY)
          mem_next.addr = bsrc_reg;
        else if (cmd_reg.op == asbm_pkg::STRING_SCAN)
          mem_next.addr = {cmd_reg.dstBank, acc_reg[31:16]};
        else
          mem_next.addr = {cmd_reg.srcBank, acc_reg[15:0]};
        // the budget still loses this cycle, as in every other cycle
        wait_next  = wait_reg - cyc(4'h1) + ((cmd_reg.op == asbm_pkg::BLOCK_COPY) ?
                     cyc(`ASBM_BLK_PER) : cyc(`ASBM_STR_PER));
        state_next = WAITRD;
      end
      WAITRD: begin
        if (rdValid) begin
          data_next  = mask(rdData, cmd_reg.wordSize);
          state_next = (cmd_reg.op == asbm_pkg::STRING_SCAN) ? FINISH : WRITE;
        end
      end
      WRITE: begin
        mem_next.req      = 1'b1;
        mem_next.write    = 1'b1;
        mem_next.wordSize = cmd_reg.wordSize;
        if (cmd_reg.op == asbm_pkg::BLOCK_COPY) begin
          mem_next.addr  = bdst_reg;
          mem_next.wdata = data_reg;
          bsrc_next      = step24(bsrc_reg, cmd_reg.wordSize);
          bdst_next      = step24(bdst_reg, cmd_reg.wordSize);
          blk_next       = blk_reg - 9'h001;
          state_next     = (blk_reg == 9'h001) ? PAD : READ;
        end else begin
          mem_next.addr   = {cmd_reg.dstBank, acc_reg[31:16]};
          acc_next[31:16] = stepOut;
          cnt_next        = cnt_reg - 16'h0001;
          if (cmd_reg.op == asbm_pkg::STRING_FILL) begin
            // fill always ascends, whatever the direction bit says
            acc_next[31:16] = step16(acc_reg[31:16], cmd_reg.wordSize, 1'b0);
            mem_next.wdata  = mask(acc_reg[15:0], cmd_reg.wordSize);
            wait_next       = wait_reg - cyc(4'h1) + cyc(`ASBM_FILL_PER);
            state_next      = (cnt_reg == 16'h0001) ? PAD : WRITE;
          end else begin
            mem_next.wdata = data_reg;
            acc_next[15:0] = step16(acc_reg[15:0], cmd_reg.wordSize, cmd_reg.down);
            state_next     = (cnt_reg == 16'h0001) ? PAD : READ;
          end
        end
      end
      FINISH: begin
        flags_next      = scanFlags;
        acc_next[31:16] = stepOut;
        cnt_next        = cnt_reg - 16'h0001;
        if (match) begin
          wait_next  = wait_reg + cyc(4'h2) - cyc(4'h1);
          state_next = PAD;
        end else
          state_next = (cnt_reg == 16'h0001) ? PAD : READ;
      end
      PAD: begin
        if (wait_reg <= cyc(4'h1)) begin
          done_next  = 1'b1;
          state_next = IDLE;
        end
      end
      default: state_next = IDLE;
    endcase
    busy_next = (state_next != IDLE);
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg   <= IDLE;
      cmd_reg     <= '0;
      acc_reg     <= '0;
      cnt_reg     <= '0;
      blk_reg     <= '0;
      bsrc_reg    <= '0;
      bdst_reg    <= '0;
      data_reg    <= '0;
      flags_reg   <= '0;
      wait_reg    <= '0;
      busy_reg    <= 1'b0;
      done_reg    <= 1'b0;
      mem_reg     <= '0;
    end else begin
      state_reg   <= state_next;
      cmd_reg     <= cmd_next;
      acc_reg     <= acc_next;
      cnt_reg     <= cnt_next;
      blk_reg     <= blk_next;
      bsrc_reg    <= bsrc_next;
      bdst_reg    <= bdst_next;
      data_reg    <= data_next;
      flags_reg   <= flags_next;
      wait_reg    <= wait_next;
      busy_reg    <= busy_next;
      done_reg    <= done_next;
      mem_reg     <= mem_next;
    end
  end

  assign busy       = busy_reg;
  assign done       = done_reg;
  assign accOut     = acc_reg;
  assign counterOut = cnt_reg;
  assign flagsOut   = flags_reg;
  assign mem        = mem_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  // exchange swaps the accumulator halves two cycles after start
  word_exchange_a: assert property (@(posedge sys_clk) disable iff (reset)
    (start && !busy && cmd.op == asbm_pkg::ACC_WORD_EXCHANGE) |=> ##2 done
      && accOut == {$past(accIn[15:0], 3), $past(accIn[31:16], 3)})
    else $error("word exchange result or timing wrong");
  byte_exchange_a: assert property (@(posedge sys_clk) disable iff (reset)
    (start && !busy && cmd.op == asbm_pkg::ACC_BYTE_EXCHANGE) |=> ##3
      (done && flagsOut == $past(flagsIn, 4)))
    else $error("byte exchange changed flags or took wrong time");
  sign_widen_a: assert property (@(posedge sys_clk) disable iff (reset)
    (start && !busy && cmd.op == asbm_pkg::BYTE_SIGN_WIDEN) |=> ##1
      (done && accOut[15:8] == {8{accOut[7]}}))
    else $error("byte sign widen wrong");
  wsign_widen_a: assert property (@(posedge sys_clk) disable iff (reset)
    (start && !busy && cmd.op == asbm_pkg::WORD_SIGN_WIDEN) |=> !done [*2] ##1
      (done && accOut[31:16] == {16{accOut[15]}} && flagsOut.negative == accOut[15]))
    else $error("word sign widen wrong");
  zero_widen_a: assert property (@(posedge sys_clk) disable iff (reset)
    (start && !busy && cmd.op == asbm_pkg::WORD_ZERO_WIDEN) |=> ##1
      (done && accOut[31:16] == 16'h0000 && !flagsOut.negative))
    else $error("zero widen wrong");
  copy_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
    (start && !busy && cmd.op == asbm_pkg::STRING_COPY && counterIn == 16'h0000)
      |=> !done [*4] ##1 done)
    else $error("empty copy not four cycles");
  scan_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
    (start && !busy && cmd.op == asbm_pkg::STRING_SCAN && counterIn == 16'h0000)
      |=> !done [*3] ##1 done)
    else $error("empty scan not three cycles");
  counter_end_a: assert property (@(posedge sys_clk) disable iff (reset)
    (done && (cmd_reg.op == asbm_pkg::STRING_COPY || cmd_reg.op == asbm_pkg::STRING_FILL))
      |-> counterOut == 16'h0000)
    else $error("string op ended with counter not zero");
  copy_flags_a: assert property (@(posedge sys_clk) disable iff (reset)
    (busy && (cmd_reg.op == asbm_pkg::STRING_COPY || cmd_reg.op == asbm_pkg::BLOCK_COPY))
      |=> $stable(flagsOut))
    else $error("copy changed flags");
  blk_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state_reg == IDLE && start && cmd.op == asbm_pkg::BLOCK_COPY && cmd.immCount == 8'h00)
      |=> blk_reg == 9'h100)
    else $error("zero immediate not 256");
endmodule : asbm_exec
`default_nettype wire

//--- asbm_mem_model.sv
// Purpose: behavioural on-chip memory answering the execution unit
// Assumes: byte store, words little-endian, unwritten bytes hold an address pattern
// Notes:   rdData toggles while no answer stands, so stale data never looks valid
`timescale 1ns/1ps
`default_nettype none
module asbm_mem_model (
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  input  wire logic                   slow,
  input  wire asbm_pkg::asbm_mem_type mem,
  output logic                        rdValid,
  output logic [15:0]                 rdData
);
  logic [7:0]  store [logic [23:0]];
  logic [23:0] pendAddr;
  logic        pendWord;
  int          waitCnt;
  function automatic logic [7:0] rd8(input logic [23:0] x);
    return store.exists(x) ? store[x] : x[7:0] ^ x[15:8] ^ 8'h3c;
  endfunction : rd8
  function automatic logic [15:0] answer(input logic [23:0] x, input logic wd);
    return {wd ? rd8(x + 24'h1) : ~rdData[15:8], rd8(x)};
  endfunction : answer
  // slow mode answers three cycles late to stretch every element
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdValid <= 1'b0;
      rdData  <= 16'h0000;
      waitCnt <= -1;
    end else begin
      rdValid <= 1'b0;
      rdData  <= ~rdData;
      if (waitCnt >= 0) waitCnt <= waitCnt - 1;
      if (waitCnt == 0) begin
        rdValid <= 1'b1;
        rdData  <= answer(pendAddr, pendWord);
      end
      if (mem.req && mem.write) begin
        store[mem.addr] = mem.wdata[7:0];
        if (mem.wordSize) store[mem.addr + 24'h1] = mem.wdata[15:8];
      end else if (mem.req && !slow) begin
        rdValid <= 1'b1;
        rdData  <= answer(mem.addr, mem.wordSize);
      end else if (mem.req) begin
        pendAddr <= mem.addr;
        pendWord <= mem.wordSize;
        waitCnt  <= 2;
      end
    end
  end
endmodule : asbm_mem_model
`default_nettype wire

//--- acc_string_block_move_exec_bench.sv
// Purpose: self-checking bench for the accumulator, string and block-copy unit
// Assumes: memory answers the cycle after a request unless slow is set
// Notes:   expectations queue up at start, the done watcher pops and compares
`timescale 1ns/1ps
`default_nettype none
module acc_string_block_move_exec_bench;
  typedef struct {
    logic [31:0] acc;
    logic [15:0] cnt;
    logic [3:0]  fl;
    int          cyc;
    int          n;
    logic [3:0]  m;
  } asbm_exp_type;
  logic                     sys_clk = 1'b0, reset = 1'b1, start = 1'b0, slow = 1'b0;
  logic                     busy, done, rdValid, w, d;
  logic [15:0]              counterIn = '0, counterOut, rdData, p, al;
  logic [31:0]              accIn = '0, accOut, a, r;
  logic [3:0]               f, fl;
  asbm_pkg::asbm_cmd_type   cmd = '0;
  asbm_pkg::asbm_flags_type flagsIn = '0, flagsOut;
  asbm_pkg::asbm_mem_type   mem;
  asbm_exp_type             mon, expQ[$];
  int                       cyc = 0, mismatches = 0, tests_run = 0, seed = 66, m, n, sz;

  asbm_exec u_dut (.sys_clk(sys_clk), .reset(reset), .start(start), .cmd(cmd),
    .accIn(accIn), .counterIn(counterIn), .flagsIn(flagsIn), .rdValid(rdValid),
    .rdData(rdData), .busy(busy), .done(done), .accOut(accOut),
    .counterOut(counterOut), .flagsOut(flagsOut), .mem(mem));
  asbm_mem_model u_mem (.sys_clk(sys_clk), .reset(reset), .slow(slow), .mem(mem),
    .rdValid(rdValid), .rdData(rdData));

  always #10 sys_clk = ~sys_clk;
  // ********************
  // helpers
  // ********************
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [7:0] pat(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h3c;
  endfunction : pat
  function automatic logic [15:0] el(input logic [23:0] x, input logic wd);
    return wd ? {pat(x + 24'h1), pat(x)} : {8'h00, pat(x)};
  endfunction : el
  // flags of element minus compare value, at element width
  function automatic logic [3:0] cmpFl(input logic [15:0] e, input logic [15:0] c, input logic wd);
    logic [16:0] t;
    t = wd ? {1'b0, e} - {1'b0, c} : {9'h000, e[7:0]} - {9'h000, c[7:0]};
    return wd ? {t[15], t[15:0] == 0, (e[15] ^ c[15]) & (e[15] ^ t[15]), t[16]}
              : {t[7], t[7:0] == 0, (e[7] ^ c[7]) & (e[7] ^ t[7]), t[8]};
  endfunction : cmpFl
  function automatic asbm_exp_type mk(input logic [31:0] x, input logic [3:0] g,
                                      input int k, input logic [3:0] mask);
    return '{x, 16'h0000, g, 0, k, mask};
  endfunction : mk
  // hold > 1 keeps start up while busy, which must be ignored
  task automatic doOp(input asbm_pkg::asbm_op_type op, input logic [15:0] c, input int hold,
                      input asbm_exp_type e);
    @(negedge sys_clk);
    cmd.op = op;
    cmd.wordSize = w;
    cmd.down = d;
    accIn = a;
    flagsIn = f;
    counterIn = c;
    start = 1'b1;
    e.cyc = cyc + 1;
    expQ.push_back(e);
    repeat (hold) @(negedge sys_clk);
    start = 1'b0;
    for (int k = 0; k < 3000 && (busy !== 1'b0 || expQ.size() != 0); k++) @(negedge sys_clk);
  endtask : doOp
  task automatic cmpMem(input logic [23:0] src, input logic [23:0] dst, input int len);
    for (int i = 0; i < len; i++)
      chk(32'(u_mem.rd8(dst + 24'(i))), 32'(pat(src + 24'(i))));
  endtask : cmpMem

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  always @(negedge sys_clk) begin
    if (done === 1'b1 && expQ.size() == 0)
      chk(32'h1, 32'h0);
    else if (done === 1'b1) begin
      mon = expQ.pop_front();
      if (mon.m[0]) chk(accOut, mon.acc);
      if (mon.m[1]) chk(32'(counterOut), 32'(mon.cnt));
      if (mon.m[2]) chk(32'(flagsOut), 32'(mon.fl));
      if (mon.m[3]) chk(32'(cyc - mon.cyc), 32'(mon.n));
    end
  end
  // ********************
  // scenarios
  // ********************
  initial begin
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    for (int i = 0; i < 24; i++) begin
      a = $random(seed);
      f = 4'($random(seed));
      if (i / 6 == 1) a[15:0] = 16'h0000;
      if (i / 6 == 2) a[15:0] = 16'h8000;
      case (i % 6)
        0: {r, fl, n} = {a[31:16], a[7:0], a[15:8], f, 32'd3};
        1: {r, fl, n} = {a[15:0], a[31:16], f, 32'd2};
        2: {r, fl, n} = {a[31:16], {8{a[7]}}, a[7:0], a[7], !a[7:0], f[1:0], 32'd1};
        3: {r, fl, n} = {{16{a[15]}}, a[15:0], a[15], !a[15:0], f[1:0], 32'd2};
        4: {r, fl, n} = {a[31:16], 8'h00, a[7:0], 1'b0, !a[7:0], f[1:0], 32'd1};
        default: {r, fl, n} = {16'h0000, a[15:0], 1'b0, !a[15:0], f[1:0], 32'd1};
      endcase
      doOp(asbm_pkg::asbm_op_type'(i % 6), 16'($random(seed)), 1, mk(r, fl, n, 4'b1101));
    end
    $display("test accumulator done");
    for (int j = 0; j < 5; j++) begin
      {d, w} = 2'(j);
      sz = w ? 2 : 1;
      m = (j == 4) ? 0 : 1 + ($random(seed) & 3);
      f = 4'($random(seed));
      slow = (j == 2);
      cmd.srcBank = 8'(2 * j + 2);
      cmd.dstBank = 8'(2 * j + 3);
      a = {16'h4020 + 16'($random(seed) & 127), 16'h4020 + 16'($random(seed) & 127)};
      r = d ? a - {16'(m * sz), 16'(m * sz)} : a + {16'(m * sz), 16'(m * sz)};
      doOp(asbm_pkg::STRING_COPY, 16'(m), slow ? 4 : 1,
           mk(r, f, m == 0 ? 4 : 2 + 6 * m, slow ? 4'b0111 : 4'b1111));
      n = d ? (m - 1) * sz : 0;
      cmpMem({cmd.srcBank, a[15:0] - 16'(n)}, {cmd.dstBank, a[31:16] - 16'(n)}, m * sz);
    end
    slow = 1'b0;
    $display("test string copy done");
    for (int j = 0; j < 5; j++) begin
      {d, w} = 2'(j);
      sz = w ? 2 : 1;
      m = (j == 4) ? 0 : 3 + j;
      f = 4'($random(seed));
      cmd.dstBank = 8'(j + 20);
      p = 16'h4020 + 16'($random(seed) & 127);
      al = el({cmd.dstBank, d ? p - 16'(sz) : p + 16'h0040}, w);
      a = {p, al};
      fl = cmpFl(el({cmd.dstBank, p + 16'((m - 1) * sz)}, w), al, w);
      if (d)
        doOp(asbm_pkg::STRING_SCAN, 16'(m), 1, mk(a, 4'b0100, 16, 4'b1100));
      else
        doOp(asbm_pkg::STRING_SCAN, 16'(m), 1, mk({p + 16'(m * sz), al}, fl,
             m == 0 ? 3 : 2 + 6 * m, m == 0 ? 4'b1011 : 4'b1111));
    end
    $display("test string scan done");
    for (int j = 0; j < 3; j++) begin
      {d, w} = {1'b0, j[0]};
      sz = w ? 2 : 1;
      m = (j == 2) ? 0 : 2 + j;
      f = 4'($random(seed));
      cmd.dstBank = 8'(j + 30);
      p = 16'h4020 + 16'($random(seed) & 127);
      al = (j == 0) ? 16'h1200 : 16'($random(seed));
      a = {p, al};
      fl = w ? {al[15], al == 0, f[1:0]} : {al[7], al[7:0] == 0, f[1:0]};
      doOp(asbm_pkg::STRING_FILL, 16'(m), 1, mk({p + 16'(m * sz), al}, fl, 5 * m + 6,
           m == 0 ? 4'b1011 : 4'b1111));
      for (int i = 0; i < m * sz; i++)
        chk(32'(u_mem.rd8({cmd.dstBank, p + 16'(i)})), 32'((w && i % 2) ? al[15:8] : al[7:0]));
    end
    $display("test string fill done");
    for (int j = 0; j < 2; j++) begin
      {d, w} = {1'b0, j[0]};
      f = 4'($random(seed));
      m = j ? 256 : 3;
      cmd.immCount = 8'(m);
      cmd.blkSrc = {8'(j + 40), 16'h1000};
      cmd.blkDst = {8'(j + 42), 16'h2000};
      doOp(asbm_pkg::BLOCK_COPY, 16'($random(seed)), 1, mk(a, f, 5 + 5 * m, 4'b1100));
      cmpMem(cmd.blkSrc, cmd.blkDst, m * (w ? 2 : 1));
    end
    $display("test block copy done");
    end_sim();
  end
endmodule : acc_string_block_move_exec_bench
`default_nettype wire
